// File: verilog/fnd_pkg.sv
// Shared constants for the fractional-N divider setup block.
// Assumes a 32-bit AHB-Lite bus with word-aligned register offsets.
package fnd_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] FND_OFS_INT = 8'h00;   // Integer divide value
  localparam logic [7:0] FND_OFS_PNUM = 8'h04; // Primary numerator
  localparam logic [7:0] FND_OFS_ANUM = 8'h08; // Auxiliary numerator
  localparam logic [7:0] FND_OFS_AMOD = 8'h0c; // Auxiliary modulus
  localparam logic [7:0] FND_OFS_RCNT = 8'h10;  // Reference count
  localparam logic [7:0] FND_OFS_CTRL = 8'h14;  // Mode bits
  localparam logic [7:0] FND_OFS_STAT = 8'h18;  // Live state, read only

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int FND_CTRL_DBL = 0;   // Reference doubler
  localparam int FND_CTRL_HALF = 1;  // Reference divide by two
  localparam int FND_CTRL_MODE = 2;  // Reference mode select
  localparam int FND_CTRL_PRESC = 3; // Prescaler choice, 1 = 8/9
  localparam int FND_CTRL_W = 4;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [15:0] FND_RST_INT = 16'h0017;
  localparam logic [23:0] FND_RST_PNUM = 24'h000000;
  localparam logic [13:0] FND_RST_ANUM = 14'h0000;
  localparam logic [13:0] FND_RST_AMOD = 14'h0002;
  localparam logic [9:0] FND_RST_RCNT = 10'h001;
  localparam logic [3:0] FND_RST_CTRL = 4'h0;

  // Fixed primary modulus, two to the twenty-fourth
  localparam logic [24:0] FND_PRIMARY_MODULUS = 25'h1000000;

  // Register selector
  typedef enum logic [2:0]
  {
    FND_R_INT,
    FND_R_PNUM,
    FND_R_ANUM,
    FND_R_AMOD,
    FND_R_RCNT,
    FND_R_CTRL,
    FND_R_STAT,
    FND_R_NONE
  } fnd_reg_t;

  // Address decode shared by the read and write paths
  function automatic fnd_reg_t fnd_decode(input logic [31:0] a);
    fnd_reg_t r;
    r = FND_R_NONE;
    if (a[31:8] == 24'h000000)
    begin
      case (a[7:0])
        FND_OFS_INT: r = FND_R_INT;
        FND_OFS_PNUM: r = FND_R_PNUM;
        FND_OFS_ANUM: r = FND_R_ANUM;
        FND_OFS_AMOD: r = FND_R_AMOD;
        FND_OFS_RCNT: r = FND_R_RCNT;
        FND_OFS_CTRL: r = FND_R_CTRL;
        FND_OFS_STAT: r = FND_R_STAT;
        default: r = FND_R_NONE;
      endcase
    end
    return r;
  endfunction

endpackage

// File: verilog/fnd_sdm.sv
// Two-stage fraction accumulator that sets the instantaneous divide.
// Assumes step and load come from the same clock domain, one cycle each.
`timescale 1ns/1ps

module fnd_sdm
#(
  parameter int PNUM_W = 24,
  parameter int AMOD_W = 14
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic load,
  input wire logic step,
  input wire logic [PNUM_W-1:0] pnum,
  input wire logic [AMOD_W-1:0] anum,
  input wire logic [AMOD_W-1:0] amod,
  output logic carry
);
  import fnd_pkg::*;

  // ------------------------------------------------------------
  // Accumulators
  // ------------------------------------------------------------
  logic [AMOD_W-1:0] acc2_reg;   // Auxiliary residue, below its modulus
  logic [PNUM_W-1:0] acc1_reg;   // Primary residue
  logic carry_reg;               // Extra count for the next cycle

  wire logic [AMOD_W:0] acc2_sum = {1'b0, acc2_reg} + {1'b0, anum};
  wire logic aux_carry = acc2_sum >= {1'b0, amod};
  wire logic [AMOD_W:0] acc2_wrap = acc2_sum - {1'b0, amod};
  wire logic [AMOD_W-1:0] acc2_next =
    aux_carry ? acc2_wrap[AMOD_W-1:0] : acc2_sum[AMOD_W-1:0];
  // Auxiliary carry feeds the primary sum, making the 38-bit fraction
  wire logic [PNUM_W:0] acc1_sum =
    {1'b0, acc1_reg} + {1'b0, pnum} + {{PNUM_W{1'b0}}, aux_carry};

  assign carry = carry_reg;

  // Step once per feedback cycle; load restarts from zero residue
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc2_reg <= '0;
      acc1_reg <= '0;
      carry_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (load)
      begin
        acc2_reg <= '0;
        acc1_reg <= '0;
        carry_reg <= 1'b0;
      end
      else if (step)
      begin
        acc2_reg <= acc2_next;
        acc1_reg <= acc1_sum[PNUM_W-1:0];
        carry_reg <= acc1_sum[PNUM_W];
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_primary_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (ce && step && !load &&
     ({1'b0, acc1_reg} + {1'b0, pnum} + {{PNUM_W{1'b0}}, aux_carry}
      >= FND_PRIMARY_MODULUS))
    |=> carry_reg;
  endproperty
  a_primary_wrap: assert property (p_primary_wrap)
    else $error("primary modulus overflow gave no carry");

  property p_aux_residue;
    @(posedge hclk) disable iff (!hresetn)
    (amod >= 2) && $stable(amod) && !$past(load) |-> acc2_reg < amod;
  endproperty
  a_aux_residue: assert property (p_aux_residue)
    else $error("auxiliary residue reached its modulus");

endmodule

// File: verilog/fnd_divider.sv
// Reference and feedback divider setup of a fractional-N synthesizer.
// Assumes an AHB-Lite master at hclk and inputs synchronous to hclk.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - Feedback ratio is int plus fraction over modulus
// - Primary modulus fixed at two^24
// - Reference counter ten bits, ratio 1 to 1023
// - Compare rate scaled by doubler and halver
// - Mode bit picks differential or single A
// - Oscillator equals compare rate times ratio
// - Zero numerators give pure integer division
module fnd_divider
#(
  parameter int INT_W = 16,
  parameter int PNUM_W = 24,
  parameter int AMOD_W = 14,
  parameter int RCNT_W = 10
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reference_input_a,
  input wire logic reference_input_b,
  input wire logic vco_in,
  output logic pfd_ref_pulse,
  output logic pfd_fb_pulse
);
  import fnd_pkg::*;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic [31:0] hrdata_reg;  // Read data, loaded in the address phase
  logic hreadyout_reg;      // Never waits
  logic hresp_reg;          // Always OKAY
  logic wr_pend_reg;        // Write data phase in progress
  fnd_reg_t wr_sel_reg;     // Target of that write
  logic [31:0] rd_mux;      // Selected read value

  // Whole-word transfers only; hsize is not checked
  wire logic addr_ok = hsel & htrans[1] & hready;
  wire fnd_reg_t acc_sel = fnd_decode(haddr);
  wire logic wr_now = wr_pend_reg;
  wire logic wr_int = wr_now && (wr_sel_reg == FND_R_INT);

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // Capture the address phase; read data is ready one edge later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= FND_R_NONE;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout_reg <= 1'b1;
      wr_pend_reg <= addr_ok & hwrite;
      wr_sel_reg <= acc_sel;
      if (addr_ok && !hwrite)
      begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Programmed values: shadow copies and the ones in use
  // ------------------------------------------------------------
  logic [INT_W-1:0] int_reg;        // Takes effect at once
  logic [PNUM_W-1:0] pnum_reg;      // Shadow
  logic [AMOD_W-1:0] anum_reg;      // Shadow
  logic [AMOD_W-1:0] amod_reg;      // Shadow
  logic [RCNT_W-1:0] rcnt_reg;      // Shadow
  logic [FND_CTRL_W-1:0] ctrl_reg;  // Mode and prescaler bits
  logic [PNUM_W-1:0] pnum_act_reg;
  logic [AMOD_W-1:0] anum_act_reg;
  logic [AMOD_W-1:0] amod_act_reg;
  logic [RCNT_W-1:0] rcnt_act_reg;
  logic dbl_act_reg;
  logic half_act_reg;

  // Software writes land in the shadows
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_reg <= INT_W'(FND_RST_INT);
      pnum_reg <= PNUM_W'(FND_RST_PNUM);
      anum_reg <= AMOD_W'(FND_RST_ANUM);
      amod_reg <= AMOD_W'(FND_RST_AMOD);
      rcnt_reg <= RCNT_W'(FND_RST_RCNT);
      ctrl_reg <= FND_RST_CTRL;
    end
    else if (ce && wr_now)
    begin
      case (wr_sel_reg)
        FND_R_INT: int_reg <= hwdata[INT_W-1:0];
        FND_R_PNUM: pnum_reg <= hwdata[PNUM_W-1:0];
        FND_R_ANUM: anum_reg <= hwdata[AMOD_W-1:0];
        FND_R_AMOD: amod_reg <= hwdata[AMOD_W-1:0];
        FND_R_RCNT: rcnt_reg <= hwdata[RCNT_W-1:0];
        FND_R_CTRL: ctrl_reg <= hwdata[FND_CTRL_W-1:0];
        default: ; // Status and unmapped writes are dropped
      endcase
    end
  end

  // Integer write commits every shadow together, so a half-updated
  // fraction never reaches the divider
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pnum_act_reg <= PNUM_W'(FND_RST_PNUM);
      anum_act_reg <= AMOD_W'(FND_RST_ANUM);
      amod_act_reg <= AMOD_W'(FND_RST_AMOD);
      rcnt_act_reg <= RCNT_W'(FND_RST_RCNT);
      dbl_act_reg <= FND_RST_CTRL[FND_CTRL_DBL];
      half_act_reg <= FND_RST_CTRL[FND_CTRL_HALF];
    end
    else if (ce && wr_int)
    begin
      pnum_act_reg <= pnum_reg;
      anum_act_reg <= anum_reg;
      amod_act_reg <= amod_reg;
      rcnt_act_reg <= rcnt_reg;
      dbl_act_reg <= ctrl_reg[FND_CTRL_DBL];
      half_act_reg <= ctrl_reg[FND_CTRL_HALF];
    end
  end

  // ------------------------------------------------------------
  // Reference path
  // ------------------------------------------------------------
  logic ref_q_reg;              // Previous reference level
  logic [RCNT_W-1:0] r_cnt_reg; // Reference events so far
  logic half_ph_reg;            // Divide-by-two phase
  logic pfd_ref_reg;            // Compare-rate pulse

  // Differential compares the pair; single-ended uses pin A alone
  wire logic mode_diff = ctrl_reg[FND_CTRL_MODE];
  wire logic ref_sel = mode_diff ?
    (reference_input_a & ~reference_input_b) : reference_input_a;
  wire logic ref_rise = ref_sel & ~ref_q_reg;
  // Doubler counts both edges, so pulses are evenly spaced only for even duty
  wire logic ref_ev = dbl_act_reg ? (ref_sel ^ ref_q_reg) : ref_rise;
  // Zero count is treated as one rather than stalling
  wire logic [RCNT_W-1:0] r_lim =
    (rcnt_act_reg == '0) ? '0 : rcnt_act_reg - 1'b1;
  wire logic r_tick = ref_ev & (r_cnt_reg >= r_lim);
  wire logic ref_tick = r_tick & (~half_act_reg | half_ph_reg);

  assign pfd_ref_pulse = pfd_ref_reg;

  // Reference counter restarts on every commit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_q_reg <= 1'b0;
      r_cnt_reg <= '0;
      half_ph_reg <= 1'b0;
      pfd_ref_reg <= 1'b0;
    end
    else if (ce)
    begin
      ref_q_reg <= ref_sel;
      pfd_ref_reg <= ref_tick;
      if (wr_int)
      begin
        r_cnt_reg <= '0;
        half_ph_reg <= 1'b0;
      end
      else if (ref_ev)
      begin
        r_cnt_reg <= r_tick ? '0 : r_cnt_reg + 1'b1;
        half_ph_reg <= half_ph_reg ^ r_tick;
      end
    end
  end

  // ------------------------------------------------------------
  // Feedback path
  // ------------------------------------------------------------
  logic vco_q_reg;              // Previous oscillator level
  logic [INT_W:0] n_cnt_reg;    // Oscillator edges this cycle
  logic pfd_fb_reg;             // Feedback pulse
  logic carry;                  // Extra count from the accumulator

  // Instantaneous divide is the integer or one more
  wire logic [INT_W:0] n_inst =
    {1'b0, int_reg} + {{INT_W{1'b0}}, carry};
  wire logic [INT_W:0] n_lim = n_inst - 1'b1;
  wire logic vco_rise = vco_in & ~vco_q_reg;
  wire logic fb_tick = vco_rise & (n_cnt_reg >= n_lim);
  wire logic int_mode = (pnum_act_reg == '0) && (anum_act_reg == '0);

  assign pfd_fb_pulse = pfd_fb_reg;

  // Count oscillator edges up to the current divide
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vco_q_reg <= 1'b0;
      n_cnt_reg <= '0;
      pfd_fb_reg <= 1'b0;
    end
    else if (ce)
    begin
      vco_q_reg <= vco_in;
      pfd_fb_reg <= fb_tick;
      if (wr_int)
      begin
        n_cnt_reg <= '0;
      end
      else if (vco_rise)
      begin
        n_cnt_reg <= fb_tick ? '0 : n_cnt_reg + 1'b1;
      end
    end
  end

  // Steps once per feedback cycle to alternate the divide
  fnd_sdm #(.PNUM_W(PNUM_W), .AMOD_W(AMOD_W)) u_sdm
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .load(wr_int),
    .step(fb_tick & ~wr_int),
    .pnum(pnum_act_reg),
    .anum(anum_act_reg),
    .amod(amod_act_reg),
    .carry(carry)
  );

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb
  begin
    case (acc_sel)
      FND_R_INT: rd_mux = 32'(int_reg);
      FND_R_PNUM: rd_mux = 32'(pnum_reg);
      FND_R_ANUM: rd_mux = 32'(anum_reg);
      FND_R_AMOD: rd_mux = 32'(amod_reg);
      FND_R_RCNT: rd_mux = 32'(rcnt_reg);
      FND_R_CTRL: rd_mux = 32'(ctrl_reg);
      FND_R_STAT: rd_mux = 32'({half_ph_reg, int_mode, n_inst});
      default: rd_mux = 32'h00000000; // Unmapped reads as zero
    endcase
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_fb_restart;
    @(posedge hclk) disable iff (!hresetn)
    ce && fb_tick && !wr_int |=> pfd_fb_reg && (n_cnt_reg == '0);
  endproperty
  a_fb_restart: assert property (p_fb_restart)
    else $error("feedback cycle did not restart");

  property p_fb_count;
    @(posedge hclk) disable iff (!hresetn)
    ce && vco_rise && !fb_tick && !wr_int
    |=> (n_cnt_reg == $past(n_cnt_reg) + 1'b1) && !pfd_fb_reg;
  endproperty
  a_fb_count: assert property (p_fb_count)
    else $error("oscillator edge miscounted");

  property p_r_bound;
    @(posedge hclk) disable iff (!hresetn)
    $stable(rcnt_act_reg) |-> r_cnt_reg <= r_lim;
  endproperty
  a_r_bound: assert property (p_r_bound)
    else $error("reference count passed its ratio");

  property p_full_rate;
    @(posedge hclk) disable iff (!hresetn)
    ce && r_tick && !half_act_reg |=> pfd_ref_reg;
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("reference tick lost without halving");

  property p_half_rate;
    @(posedge hclk) disable iff (!hresetn)
    ce && r_tick && half_act_reg && !half_ph_reg && !wr_int
    |=> !pfd_ref_reg ##0 half_ph_reg;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("halver let a first tick through");

  property p_single_ended;
    @(posedge hclk) disable iff (!hresetn)
    ce && !mode_diff && ref_rise |-> reference_input_a && !ref_q_reg;
  endproperty
  a_single_ended: assert property (p_single_ended)
    else $error("single-ended mode used the wrong pin");

  property p_int_only;
    @(posedge hclk) disable iff (!hresetn)
    int_mode && $past(int_mode) |-> n_inst == {1'b0, int_reg};
  endproperty
  a_int_only: assert property (p_int_only)
    else $error("integer mode divided by a fraction");

  property p_read_zero_wait;
    @(posedge hclk) disable iff (!hresetn)
    ce && addr_ok && !hwrite |=> hreadyout_reg && !hresp_reg;
  endproperty
  a_read_zero_wait: assert property (p_read_zero_wait)
    else $error("read was not answered at once");

  c_frac_step: cover property (@(posedge hclk) fb_tick && carry);
  c_half_tick: cover property (@(posedge hclk) ref_tick && half_act_reg);
  c_commit: cover property (@(posedge hclk) wr_int && !int_mode);

endmodule

// File: dv/fnd_sig_src.sv
// Far-side model: reference pins and oscillator feedback source.
// Assumes the bench sets half periods of at least one hclk cycle.
`timescale 1ns/1ps

module fnd_sig_src
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [11:0] ref_half,
  input wire logic [11:0] vco_half,
  input wire logic b_same,
  output logic reference_input_a,
  output logic reference_input_b,
  output logic vco_in
);
  logic [11:0] ref_cnt; // Cycles left in reference half
  logic [11:0] vco_cnt; // Cycles left in oscillator half

  // Pin A always carries the reference; B is its complement unless a
  // broken pair with both pins equal is asked for
  assign reference_input_b =
    b_same ? reference_input_a : ~reference_input_a;

  // Square waves, each level held at least one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_cnt <= 12'h001;
      vco_cnt <= 12'h001;
      reference_input_a <= 1'b0;
      vco_in <= 1'b0;
    end
    else
    begin
      ref_cnt <= (ref_cnt <= 12'h001) ? ref_half : ref_cnt - 12'h001;
      vco_cnt <= (vco_cnt <= 12'h001) ? vco_half : vco_cnt - 12'h001;
      if (ref_cnt <= 12'h001)
        reference_input_a <= ~reference_input_a;
      if (vco_cnt <= 12'h001)
        vco_in <= ~vco_in;
    end
  end
endmodule

// File: dv/fnd_divider_bench.sv
// Self-checking bench for the divider setup block over AHB-Lite.
// Assumes the far-side model makes reference and oscillator signals.
`timescale 1ns/1ps

module fnd_divider_bench;
  import fnd_pkg::*;

  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ref_a;
  logic ref_b;
  logic vco;
  logic pfd_ref_pulse;
  logic pfd_fb_pulse;
  logic b_same = 1'b0; // Broken differential pair when high
  logic fb_sel = 1'b0; // Which pulse the span task watches
  logic [31:0] rd; // Last word read
  int n_fail = 0;
  int tests_run = 0;
  int cyc; // Measured span in cycles
  wire logic pulse_w = fb_sel ? pfd_fb_pulse : pfd_ref_pulse;

  // Offsets, reset values and field masks
  logic [7:0] ofs [6] = '{FND_OFS_INT, FND_OFS_PNUM, FND_OFS_ANUM,
    FND_OFS_AMOD, FND_OFS_RCNT, FND_OFS_CTRL};
  logic [31:0] rst [6] = '{32'h17, 32'h0, 32'h0, 32'h2, 32'h1, 32'h0};
  logic [31:0] msk [6] = '{32'hffff, 32'hffffff, 32'h3fff, 32'h3fff,
    32'h3ff, 32'hf};
  // Reference cases: count, control, broken pair, expected span
  int t_rc [9] = '{5, 5, 5, 5, 1, 1023, 1, 1, 1};
  logic [31:0] t_ct [9] = '{0, 1, 2, 3, 0, 0, 4, 4, 0};
  logic t_bs [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  int t_ex [9] = '{20, 10, 40, 20, 4, 4092, 4, 0, 4};

  // Clock, 25 ns period
  initial
  begin
    forever #12.5 hclk = ~hclk;
  end

  // ----------------------------------------------------------
  // Instances
  // ----------------------------------------------------------
  fnd_divider dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reference_input_a(ref_a),
    .reference_input_b(ref_b), .vco_in(vco),
    .pfd_ref_pulse(pfd_ref_pulse), .pfd_fb_pulse(pfd_fb_pulse));

  fnd_sig_src src_u (.hclk(hclk), .hresetn(hresetn), .ref_half(12'h002),
    .vco_half(12'h001), .b_same(b_same), .reference_input_a(ref_a),
    .reference_input_b(ref_b), .vco_in(vco));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single transfer; held until hready is seen high
  task automatic ahb_xfer(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    ahb_xfer(1'b0, a, 32'h0);
    check_data(rd, exp);
    // Response must be OKAY at the same edge as the data
    check_data({31'h0, hresp}, 32'h0);
  endtask

  // Setup with the auxiliary pair zero over two; integer write commits
  task automatic cfg(input logic [31:0] f1, input int rc,
    input logic [31:0] ct);
    ahb_xfer(1'b1, {24'h0, FND_OFS_PNUM}, f1);
    ahb_xfer(1'b1, {24'h0, FND_OFS_ANUM}, 32'h0);
    ahb_xfer(1'b1, {24'h0, FND_OFS_AMOD}, 32'h2);
    ahb_xfer(1'b1, {24'h0, FND_OFS_RCNT}, 32'(rc));
    ahb_xfer(1'b1, {24'h0, FND_OFS_CTRL}, ct);
    ahb_xfer(1'b1, {24'h0, FND_OFS_INT}, 32'h17);
  endtask

  // Cycles spanned by n pulse intervals; zero if no pulse comes
  task automatic span(input int n);
    int k;
    k = 0;
    cyc = 0;
    while (k < 5000 && pulse_w !== 1'b1)
    begin
      @(posedge hclk);
      k++;
    end
    if (k < 5000)
    begin
      repeat (n)
      begin
        @(posedge hclk);
        cyc++;
        while (cyc < 20000 && pulse_w !== 1'b1)
        begin
          @(posedge hclk);
          cyc++;
        end
      end
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    // Reset values, then field widths with all ones written
    for (int i = 0; i < 6; i++)
    begin
      rd_chk({24'h0, ofs[i]}, rst[i]);
      ahb_xfer(1'b1, {24'h0, ofs[i]}, 32'hffffffff);
      rd_chk({24'h0, ofs[i]}, msk[i]);
    end
    // Unmapped places read zero and ignore writes
    ahb_xfer(1'b1, 32'h1c, 32'hffffffff);
    rd_chk(32'h1c, 32'h0);
    rd_chk(32'h100, 32'h0);
    // Integer mode: 23 rising edges two cycles apart per pulse
    cfg(32'h0, 1, 32'h0);
    ahb_xfer(1'b0, {24'h0, FND_OFS_STAT}, 32'h0);
    check_data(rd & 32'h3ffff, 32'h20017);
    fb_sel <= 1'b1;
    @(posedge hclk);
    span(4);
    check_count(cyc, 4 * 46);
    // Half fraction over the fixed modulus: average of 23.5 edges
    cfg(32'h00800000, 1, 32'h0);
    ahb_xfer(1'b0, {24'h0, FND_OFS_STAT}, 32'h0);
    check_data(rd & 32'h20000, 32'h0);
    span(16);
    check_count(cyc, 16 * 47);
    // Reference count, doubler, halver and input mode cases
    fb_sel <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      b_same <= t_bs[i];
      cfg(32'h0, t_rc[i], t_ct[i]);
      // Let pulses of the old setting drain before measuring
      repeat (2) @(posedge hclk);
      span(1);
      check_count(cyc, t_ex[i]);
    end
    end_of_test();
  end
endmodule
